// *** src/mfp_pkg.sv ***
package mfp_pkg;

    localparam int NPINS = 8;
    localparam int FSEL_W = 3;
    localparam int NFLAGS = 12;
    localparam int TMO_W = 24;

    // Register offsets
    localparam logic [7:0] ADDR_IN_LVL = 8'h1E;
    localparam logic [7:0] ADDR_OUT_LVL = 8'h3E;
    localparam logic [7:0] ADDR_FSEL_A = 8'h3F;
    localparam logic [7:0] ADDR_FSEL_B = 8'h40;
    localparam logic [7:0] ADDR_FSEL_C = 8'h41;
    localparam logic [7:0] ADDR_DRV = 8'h42;

    // Reset and read-back values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam logic [TMO_W-1:0] TMO_ZERO = 24'h000000;
    localparam logic [TMO_W-1:0] TMO_ONE = 24'h000001;

    // Pins on which a code has a function, bit n-1 for pin n
    localparam logic [7:0] PRI_MASK = 8'h7B;
    localparam logic [7:0] ANY_MASK = 8'h5D;
    localparam logic [7:0] MR_MASK = 8'h55;
    localparam logic [7:0] WDO_MASK = 8'hAA;
    localparam logic [7:0] KICK_MASK = 8'h01;
    localparam logic [7:0] EXT_MASK = 8'h88;
    localparam logic [7:0] MARGIN_MASK = 8'h20;

    typedef enum logic [2:0] {
        FN_IN = 3'b000,
        FN_OUT = 3'b001,
        FN_SEC = 3'b010,
        FN_PRI = 3'b011,
        FN_ANY = 3'b100,
        FN_OVC = 3'b101,
        FN_MRWD = 3'b110,
        FN_ALT = 3'b111
    } mfp_func_t;

    // Signals from the monitor logic toward the pins
    typedef struct packed {
        logic primary_fault_out;
        logic secondary_fault_out;
        logic any_fault;
        logic current_limit_out;
        logic watchdog_expired_out;
        logic ext_fault_drive;
    } mfp_src_t;

    // What one pin does under its function code
    typedef struct packed {
        logic drive;
        logic level;
        logic manual_reset_in;
        logic watchdog_kick_in;
        logic external_fault_io;
        logic margin_in;
    } mfp_role_t;

    // Nonvolatile copies loaded at power-up
    typedef struct packed {
        logic [7:0] out_lvl;
        logic [7:0] fsel_a;
        logic [7:0] fsel_b;
        logic [7:0] fsel_c;
        logic [7:0] drv;
    } mfp_flash_t;

endpackage

// *** src/mfp_pin_cell.sv ***
`timescale 1ns/1ns
module mfp_pin_cell
    import mfp_pkg::*;
#(
    parameter int PIN = 0
)(
    input wire logic [FSEL_W-1:0] code,
    input wire logic out_bit,
    input wire mfp_src_t src,
    output mfp_role_t role
);

    mfp_func_t fn;

    assign fn = mfp_func_t'(code);

    ////////////////////////////////////////////////////////////////////
    // Function decode
    wire d_out = (fn == FN_OUT);
    wire d_sec = (fn == FN_SEC);
    wire d_pri = (fn == FN_PRI) && PRI_MASK[PIN];
    wire d_any = (fn == FN_ANY) && ANY_MASK[PIN];
    wire d_ovc = (fn == FN_OVC);
    wire d_wdo = (fn == FN_MRWD) && WDO_MASK[PIN];
    wire d_ext = (fn == FN_ALT) && EXT_MASK[PIN];

    ////////////////////////////////////////////////////////////////////
    // Drive request and level; other codes leave the pin undriven
    wire drive = d_out | d_sec | d_pri | d_any | d_ovc | d_wdo
               | (d_ext & src.ext_fault_drive);

    wire level = d_out ? out_bit :
                 d_sec ? src.secondary_fault_out :
                 d_pri ? src.primary_fault_out :
                 d_any ? ~src.any_fault :
                 d_ovc ? ~src.current_limit_out :
                 d_wdo ? ~src.watchdog_expired_out :
                 1'b0;

    // Drive request and input roles, one driver for the whole word
    assign role = '{
        drive: drive,
        level: level,
        manual_reset_in: (fn == FN_MRWD) && MR_MASK[PIN],
        watchdog_kick_in: (fn == FN_ALT) && KICK_MASK[PIN],
        external_fault_io: d_ext,
        margin_in: (fn == FN_ALT) && MARGIN_MASK[PIN]
    };

endmodule // mfp_pin_cell

// *** src/mfp_port.sv ***
`timescale 1ns/1ns
module mfp_port
    import mfp_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // Register port from the serial configuration engine
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Nonvolatile image and its load strobe
    input wire logic FLASH_LOAD,
    input wire mfp_flash_t FLASH_IMG,
    // Pins
    input wire logic [NPINS-1:0] PIN_I,
    output logic [NPINS-1:0] PIN_O,
    output logic [NPINS-1:0] PIN_OE,
    // Monitor logic
    input wire logic PRIMARY_FAULT,
    input wire logic SECONDARY_FAULT,
    input wire logic [NFLAGS-1:0] FAULT_FLAGS,
    input wire logic CURRENT_LIMIT,
    input wire logic WATCHDOG_EXPIRED,
    input wire logic EXT_FAULT_DRIVE,
    input wire logic [TMO_W-1:0] RST_TIMEOUT,
    // Decoded pin roles
    output logic RESET_OUT,
    output logic WATCHDOG_KICK,
    output logic EXT_FAULT_SEEN,
    output logic MARGIN_REQ
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] out_lvl_q;
    logic [7:0] fsel_a_q;
    logic [7:0] fsel_b_q;
    logic [7:0] fsel_c_q;
    logic [7:0] drv_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [NPINS-1:0] pin_meta_q;
    logic [NPINS-1:0] pin_s_q;
    logic [NPINS-1:0] pin_o_d;
    logic [NPINS-1:0] pin_oe_d;
    logic [NPINS-1:0] pin_o_q;
    logic [NPINS-1:0] pin_oe_q;
    logic [NPINS-1:0] mr_sel;
    logic [NPINS-1:0] kick_sel;
    logic [NPINS-1:0] ext_sel;
    logic [NPINS-1:0] margin_sel;
    logic [TMO_W-1:0] tmo_q;
    logic [TMO_W-1:0] tmo_d;
    logic rst_q;
    logic rst_d;
    logic kick_q;
    logic ext_q;
    logic margin_q;
    logic [NPINS*FSEL_W-1:0] fsel_all;
    mfp_src_t src;
    mfp_role_t role [NPINS];

    ////////////////////////////////////////////////////////////////////
    // Address decode
    wire hit_in = (REG_ADDR == ADDR_IN_LVL);
    wire hit_out = (REG_ADDR == ADDR_OUT_LVL);
    wire hit_a = (REG_ADDR == ADDR_FSEL_A);
    wire hit_b = (REG_ADDR == ADDR_FSEL_B);
    wire hit_c = (REG_ADDR == ADDR_FSEL_C);
    wire hit_drv = (REG_ADDR == ADDR_DRV);
    wire wr_ok = REG_WR & ~FLASH_LOAD;

    ////////////////////////////////////////////////////////////////////
    // Writable registers; flash load takes priority over a write
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            out_lvl_q <= REG_RST;
            fsel_a_q <= REG_RST;
            fsel_b_q <= REG_RST;
            fsel_c_q <= REG_RST;
            drv_q <= REG_RST;
        end
        else if (CLK_EN)
        begin
            if (FLASH_LOAD)
            begin
                out_lvl_q <= FLASH_IMG.out_lvl;
                fsel_a_q <= FLASH_IMG.fsel_a;
                fsel_b_q <= FLASH_IMG.fsel_b;
                fsel_c_q <= FLASH_IMG.fsel_c;
                drv_q <= FLASH_IMG.drv;
            end
            if (wr_ok && hit_out)
                out_lvl_q <= REG_WDATA;
            if (wr_ok && hit_a)
                fsel_a_q <= REG_WDATA;
            if (wr_ok && hit_b)
                fsel_b_q <= REG_WDATA;
            if (wr_ok && hit_c)
                fsel_c_q <= REG_WDATA;
            if (wr_ok && hit_drv)
                drv_q <= REG_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read-back mux
    assign rdata_d = hit_in ? pin_s_q :
                     hit_out ? out_lvl_q :
                     hit_a ? fsel_a_q :
                     hit_b ? fsel_b_q :
                     hit_c ? fsel_c_q :
                     hit_drv ? drv_q :
                     RD_UNMAPPED;

    // Read data register
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            rdata_q <= REG_RST;
        else if (CLK_EN && REG_RD)
            rdata_q <= rdata_d;
    end

    assign REG_RDATA = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // Pin input synchroniser, two stages
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            pin_meta_q <= REG_RST;
            pin_s_q <= REG_RST;
        end
        else if (CLK_EN)
        begin
            pin_meta_q <= PIN_I;
            pin_s_q <= pin_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Function fields: pin n occupies bits 3n-3..3n-1 of {c,b,a}
    assign fsel_all = {fsel_c_q, fsel_b_q, fsel_a_q};

    // Sources toward the pins, one driver for the whole word
    assign src = '{
        primary_fault_out: PRIMARY_FAULT,
        secondary_fault_out: SECONDARY_FAULT,
        any_fault: |FAULT_FLAGS,
        current_limit_out: CURRENT_LIMIT,
        watchdog_expired_out: WATCHDOG_EXPIRED,
        ext_fault_drive: EXT_FAULT_DRIVE
    };

    ////////////////////////////////////////////////////////////////////
    // One decode cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++)
        begin : g_pin
            mfp_pin_cell #(
                .PIN(gi)
            ) u_cell (
                .code(fsel_all[gi*FSEL_W +: FSEL_W]),
                .out_bit(out_lvl_q[gi]),
                .src(src),
                .role(role[gi])
            );
            // Driver: open-drain releases on a one
            assign pin_o_d[gi] = role[gi].level & ~drv_q[gi];
            assign pin_oe_d[gi] = role[gi].drive
                & (~drv_q[gi] | ~role[gi].level);
            assign mr_sel[gi] = role[gi].manual_reset_in;
            assign kick_sel[gi] = role[gi].watchdog_kick_in;
            assign ext_sel[gi] = role[gi].external_fault_io;
            assign margin_sel[gi] = role[gi].margin_in;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Pin output registers
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            pin_o_q <= REG_RST;
            pin_oe_q <= REG_RST;
        end
        else if (CLK_EN)
        begin
            pin_o_q <= pin_o_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign PIN_O = pin_o_q;
    assign PIN_OE = pin_oe_q;

    ////////////////////////////////////////////////////////////////////
    // Manual reset: hold while low, then count the timeout
    wire mr_low = |(mr_sel & ~pin_s_q);

    assign tmo_d = mr_low ? RST_TIMEOUT :
                   (tmo_q != TMO_ZERO) ? tmo_q - TMO_ONE :
                   TMO_ZERO;
    assign rst_d = mr_low | (tmo_q != TMO_ZERO);

    // Reset timer and output
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            tmo_q <= TMO_ZERO;
            rst_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            tmo_q <= tmo_d;
            rst_q <= rst_d;
        end
    end

    assign RESET_OUT = rst_q;

    ////////////////////////////////////////////////////////////////////
    // Other input roles, from the synchronised pin levels
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            kick_q <= 1'b0;
            ext_q <= 1'b0;
            margin_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            kick_q <= |(kick_sel & pin_s_q);
            ext_q <= |(ext_sel & ~pin_s_q);
            margin_q <= |(margin_sel & pin_s_q);
        end
    end

    assign WATCHDOG_KICK = kick_q;
    assign EXT_FAULT_SEEN = ext_q;
    assign MARGIN_REQ = margin_q;

endmodule // mfp_port

// *** dv/mfp_pins_model.sv ***
`timescale 1ns/1ns
module mfp_pins_model
(
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_lvl,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_lvl
);
    // Device driver wins, then board driver, else board pull-up
    assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_lvl)
        | (~pin_oe & ~ext_en);
endmodule // mfp_pins_model

// *** dv/mfp_port_asserts.sv ***
`timescale 1ns/1ns
module mfp_port_asserts
    import mfp_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic FLASH_LOAD,
    input wire mfp_flash_t FLASH_IMG,
    input wire logic [NPINS-1:0] PIN_I,
    input wire logic [NPINS-1:0] PIN_O,
    input wire logic [NPINS-1:0] PIN_OE,
    input wire logic RESET_OUT
);
    // Requests taken at each edge
    wire rd_go = CLK_EN && REG_RD;
    wire wr_go = CLK_EN && REG_WR && !FLASH_LOAD;
    wire wr_map = REG_ADDR >= ADDR_OUT_LVL && REG_ADDR <= ADDR_DRV;
    wire mapped = wr_map || REG_ADDR == ADDR_IN_LVL;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////////////
    rst_vals_a: assert property ($fell(SYS_RST) && $past(CLK_EN) |->
        PIN_OE == '0 && REG_RDATA == REG_RST && !RESET_OUT)
        else $error("outputs not at reset values");
    rd_hold_a: assert property (!rd_go |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    freeze_a: assert property (!CLK_EN |=> $stable(PIN_OE) && $stable(PIN_O)
        && $stable(RESET_OUT)) else $error("state moved while frozen");
    rd_unmap_a: assert property (rd_go && !mapped |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    wr_back_a: assert property (
        wr_go && wr_map ##1 rd_go && !REG_WR && !FLASH_LOAD
        && REG_ADDR == $past(REG_ADDR) |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("write not read back");
    flash_lvl_a: assert property (
        CLK_EN && FLASH_LOAD ##1 rd_go && !REG_WR && !FLASH_LOAD
        && REG_ADDR == ADDR_OUT_LVL
        |=> REG_RDATA == $past(FLASH_IMG.out_lvl, 2))
        else $error("output levels not loaded from flash");
    fl_drop_a: assert property (
        CLK_EN && FLASH_LOAD ##1 rd_go && !REG_WR && !FLASH_LOAD
        && REG_ADDR == ADDR_DRV |=> REG_RDATA == $past(FLASH_IMG.drv, 2))
        else $error("driver type not loaded from flash");
    in_level_a: assert property (
        (CLK_EN && $stable(PIN_I))[*3] ##0 rd_go && REG_ADDR == ADDR_IN_LVL
        |=> REG_RDATA == $past(PIN_I)) else $error("input levels wrong");
endmodule // mfp_port_asserts

bind mfp_port mfp_port_asserts chk_u (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .FLASH_LOAD(FLASH_LOAD), .FLASH_IMG(FLASH_IMG), .PIN_I(PIN_I),
    .PIN_O(PIN_O), .PIN_OE(PIN_OE), .RESET_OUT(RESET_OUT));

// *** dv/testbench.sv ***
`timescale 1ns/1ns
module testbench
    import mfp_pkg::*;
;
    logic clk = 0, rst = 1, en = 1, wr = 0, rd = 0, fl = 0, ro;
    logic kk, ef, mg;
    logic [7:0] adr = 0, wd = 0, rdat, p_o, p_oe, p_i, xl = 0, xe = 0;
    logic [4:0] src = 5'h1F;
    logic [11:0] flg = 12'h001;
    logic [23:0] c;
    mfp_flash_t img = '0;
    int err_count = 0, samples_checked = 0;
    // Pins driven per code when sources are active
    localparam logic [7:0] OE_T [8] = '{8'h00, 8'hFF, 8'hFF, 8'h7B,
        8'h5D, 8'hFF, 8'hAA, 8'h88};
    mfp_port dut_u (.CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(en), .REG_ADDR(adr),
        .REG_WR(wr), .REG_WDATA(wd), .REG_RD(rd), .REG_RDATA(rdat),
        .FLASH_LOAD(fl), .FLASH_IMG(img), .PIN_I(p_i), .PIN_O(p_o),
        .PIN_OE(p_oe), .PRIMARY_FAULT(src[0]), .SECONDARY_FAULT(src[1]),
        .FAULT_FLAGS(flg), .CURRENT_LIMIT(src[2]), .WATCHDOG_EXPIRED(src[3]),
        .EXT_FAULT_DRIVE(src[4]), .RST_TIMEOUT(24'h000005), .RESET_OUT(ro),
        .WATCHDOG_KICK(kk), .EXT_FAULT_SEEN(ef), .MARGIN_REQ(mg));
    mfp_pins_model pins_u (.pin_o(p_o), .pin_oe(p_oe), .ext_lvl(xl),
        .ext_en(xe), .pin_lvl(p_i));
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // Expected {oe, o} from codes, levels, driver type, source state
    function automatic logic [15:0] expv(logic [23:0] cv, logic [7:0] lv,
        logic [7:0] dv, logic a);
        logic [7:0] oe, o;
        logic [2:0] k;
        for (int n = 0; n < 8; n++)
        begin
            k = cv[3*n+:3];
            oe[n] = OE_T[k][n] && !(k == 3'd7 && !a);
            o[n] = k == 3'd1 ? lv[n] : (k == 3'd2 || k == 3'd3) ? a : !a;
            if (dv[n])
            begin
                oe[n] = oe[n] && !o[n];
                o[n] = 1'b0;
            end
            o[n] = o[n] && oe[n];
        end
        return {oe, o};
    endfunction
    task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Strobes stay up until the next call or bus_idle
    task automatic wrr(logic [7:0] a, logic [7:0] d);
        adr = a;
        wd = d;
        rd = 0;
        wr = 1;
        @(negedge clk);
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] e);
        adr = a;
        wr = 0;
        rd = 1;
        @(negedge clk);
        cmp("register", e, rdat);
    endtask
    // Drop both strobes and let one edge pass
    task automatic bus_idle;
        wr = 0;
        rd = 0;
        @(negedge clk);
    endtask
    task automatic pchk(logic [23:0] cv, logic [7:0] lv, logic [7:0] dv,
        logic a);
        logic [15:0] x;
        x = expv(cv, lv, dv, a);
        cmp("pin_oe", x[15:8], p_oe);
        cmp("pin_o", x[7:0], p_o & p_oe);
    endtask
    task automatic cfg(logic [23:0] cv, logic [7:0] lv, logic [7:0] dv);
        wrr(ADDR_OUT_LVL, lv);
        wrr(ADDR_FSEL_A, cv[7:0]);
        wrr(ADDR_FSEL_B, cv[15:8]);
        wrr(ADDR_FSEL_C, cv[23:16]);
        wrr(ADDR_DRV, dv);
        bus_idle;
        @(negedge clk);
    endtask
    // Flash load with a colliding write that must be dropped
    task automatic fld(logic [39:0] v, logic [7:0] ra, logic [7:0] e);
        img = v;
        fl = 1;
        wrr(ADDR_DRV, ~v[7:0]);
        fl = 0;
        rdc(ra, e);
    endtask
    task automatic end_sim;
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (6) @(negedge clk);
        rst = 0;
        rdc(ADDR_OUT_LVL, 8'h00);
        rdc(8'h20, 8'h00);
        fld({8'hA5, 8'h49, 8'h92, 8'h24, 8'h0F}, ADDR_OUT_LVL, 8'hA5);
        bus_idle;
        pchk(24'h249249, 8'hA5, 8'h0F, 1);
        fld({8'h5A, 8'h49, 8'h92, 8'h24, 8'hC3}, ADDR_DRV, 8'hC3);
        wrr(ADDR_OUT_LVL, 8'h3C);
        bus_idle;
        @(negedge clk);
        pchk(24'h249249, 8'h3C, 8'hC3, 1);
        // Every code on all pins, then a mix: pins 1..8 = 4,1,3,7,6,2,0,5
        for (int i = 0; i < 18; i++)
        begin
            c = i % 9 < 8 ? {8{3'(i % 9)}} : 24'hA16ECC;
            // Combined fault from the top flag once, bit 0 in the rest of the first pass, no flags in the second
            {src, flg} = i < 9 ? {5'h1F, (i == 4 ? 12'h800 : 12'h001)}
                : 17'h0;
            cfg(c, 8'hFF, 8'h00);
            pchk(c, 8'hFF, 8'h00, i < 9);
            // Input roles after the pins have passed the synchroniser
            repeat (3) @(negedge clk);
            cmp("roles", {5'h0, i % 9 == 7, i == 7 || i == 8, i % 9 == 7},
                {5'h0, kk, ef, mg});
        end
        en = 0;
        wrr(ADDR_OUT_LVL, 8'h00);
        bus_idle;
        en = 1;
        rdc(ADDR_OUT_LVL, 8'hFF);
        wrr(ADDR_DRV, 8'h96);
        rdc(ADDR_DRV, 8'h96);
        xl = 8'h3C;
        xe = 8'hFF;
        cfg(24'h000000, 8'hFF, 8'h00);
        wrr(ADDR_IN_LVL, 8'hFF);
        rdc(ADDR_IN_LVL, 8'h3C);
        // Code 111 everywhere, board levels decide the input roles
        cfg(24'hFFFFFF, 8'hFF, 8'h00);
        cmp("roles", 8'h03, {5'h0, kk, ef, mg});
        xl = 8'h00;
        xe = 8'h01;
        cfg(24'h000006, 8'hFF, 8'h00);
        cmp("reset_out", 8'h01, {7'h0, ro});
        xl = 8'h01;
        repeat (4) @(negedge clk);
        cmp("reset_out", 8'h01, {7'h0, ro});
        // Stretch ends six clocks after the synchronised pin rises
        repeat (3) @(negedge clk);
        cmp("reset_out", 8'h01, {7'h0, ro});
        @(negedge clk);
        cmp("reset_out", 8'h00, {7'h0, ro});
        end_sim;
    end
    // Hang guard
    initial
    begin
        #100000;
        err_count++;
        end_sim;
    end
endmodule // testbench
